// ### src/rfti_pkg.sv
// Behaviour
// - latch six crc msbs after last dest bit
// - one-hot decode picks one of 64 bits
// - multicast accepted only if chosen bit set
// - bit n in register n/8, position n%8
// - three 8-bit tallies, halt at 192
// - tally read returns count then clears
// - alignment tally counts accepted misaligned packets
// - crc tally counts accepted crc-error packets
// - lost tally counts packets lacking buffers
// - monitor mode: lost tally counts accepted packets
// - loopback port holds last eight bytes, reads advance
// - collision count zero when no collision
// - excessive collisions set abort, count reads zero
// - setting transmit-go clears collision count
// - reset sets documented command, flag, config bits
// - halted until a command write clears halt or sets start: no packet accepted or sent, hash filter still sets mc_accept_reg, lost tally still counts no_buffer
// - tally msb setting raises interrupt flag
// - loop select codes 00,01,10,11
package rfti_pkg;
  // ==================== command bits
  localparam int CMD_HALT = 0;
  localparam int CMD_RUN = 1;
  localparam int CMD_TXGO = 2;
  localparam int CMD_ABORT = 5;
  localparam int CMD_PAGE = 6;
  localparam logic [7:0] CMD_RESET = 8'h21;
  // ==================== other bit positions and reset values
  localparam int FLAG_RST = 7;
  localparam int FLAG_TALLY = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam logic [7:0] DCFG_RESET = 8'h08;
  localparam int LOOP_LO = 1;
  localparam int LOOP_HI = 2;
  localparam int RCFG_MONITOR = 5;
  localparam int TSR_COL = 2;
  localparam int TSR_ABT = 3;
  localparam logic [7:0] TALLY_MAX = 8'hc0;
  localparam logic [3:0] NCOL_MAX = 4'hf;
  // ==================== crc
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam int HASH_LSB = 26;
  // ==================== register offsets, page 0
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_TSR = 4'h4;
  localparam logic [3:0] OFS_NCOL = 4'h5;
  localparam logic [3:0] OFS_LBPORT = 4'h6;
  localparam logic [3:0] OFS_FLAGS = 4'h7;
  localparam logic [3:0] OFS_RCFG = 4'hc;
  localparam logic [3:0] OFS_TALLY_A = 4'hd;
  localparam logic [3:0] OFS_TALLY_C = 4'he;
  localparam logic [3:0] OFS_TALLY_L = 4'hf;
  localparam logic [3:0] OFS_TCFG = 4'hd;
  localparam logic [3:0] OFS_DCFG = 4'he;
  localparam logic [3:0] OFS_MASK = 4'hf;
  // ==================== page 1: filter registers at 8..15
  localparam logic [3:0] OFS_FILTER = 4'h8;
  localparam logic [1:0] PAGE0 = 2'h0;
  localparam logic [1:0] PAGE1 = 2'h1;
  typedef enum logic [1:0] {
    RFTI_NORMAL = 2'h0,
    RFTI_LOOP_CTRL = 2'h1,
    RFTI_LOOP_CODEC = 2'h2,
    RFTI_LOOP_HUB = 2'h3
  } rfti_loop_t;
endpackage : rfti_pkg

// ### src/rfti_tally.sv
`timescale 1ns/1ps
`default_nettype none
module rfti_tally (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inc,
  input wire logic rd_clr,
  output logic [7:0] count_reg,
  output logic msb_rise_reg
);
  import rfti_pkg::*;
  logic [7:0] count_next;
  logic msb_rise_next;

  always_comb begin
    count_next = count_reg;
    if (rd_clr) begin
      // an event in the read cycle is kept, not lost
      count_next = inc ? 8'h01 : 8'h00;
    end else if (inc && count_reg < TALLY_MAX) begin
      count_next = count_reg + 8'h01;
    end
    msb_rise_next = count_next[7] && !count_reg[7];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 8'h00;
      msb_rise_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      msb_rise_reg <= msb_rise_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_tally_ceiling: assert property (count_reg <= TALLY_MAX)
    else $error("tally passed its ceiling");
  a_tally_hold: assert property (
    count_reg == TALLY_MAX && !rd_clr |=> count_reg == TALLY_MAX)
    else $error("saturated tally moved");
  a_read_clear: assert property (rd_clr && !inc |=> count_reg == 8'h00)
    else $error("tally not cleared by read");
  a_read_inc: assert property (rd_clr && inc |=> count_reg == 8'h01)
    else $error("event lost in read cycle");
endmodule : rfti_tally
`default_nettype wire

// ### src/rfti_top.sv
`timescale 1ns/1ps
`default_nettype none
module rfti_top (
  input wire logic clk,
  input wire logic resetn,
  // host register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_reg,
  // receive path
  input wire logic frame_start,
  input wire logic da_bit_valid,
  input wire logic da_bit,
  input wire logic da_last,
  input wire logic pkt_done,
  input wire logic addr_match,
  input wire logic align_err,
  input wire logic crc_err,
  input wire logic no_buffer,
  // loopback bytes and transmit events
  input wire logic lb_byte_valid,
  input wire logic [7:0] lb_byte,
  input wire logic tx_collision,
  input wire logic tx_excess,
  input wire logic tx_done,
  // status out
  output logic mc_valid_reg,
  output logic mc_accept_reg,
  output logic halted_reg,
  output logic transmit_go_reg,
  output var rfti_pkg::rfti_loop_t loop_mode_reg
);
  import rfti_pkg::*;

  // ==================== control registers
  logic [7:0] command_reg, command_next;
  logic [7:0] interrupt_flags_reg, interrupt_flags_next;
  logic [7:0] interrupt_enable_mask_reg, interrupt_enable_mask_next;
  logic [7:0] data_config_reg, data_config_next;
  logic [7:0] tx_config_reg, tx_config_next;
  logic [7:0] rx_config_reg, rx_config_next;
  logic [63:0] hash_filter_bits_reg, hash_filter_bits_next;
  logic [1:0] page;
  logic wr0, wr1, rd0;
  logic [2:0] msb_rise;

  assign page = command_reg[CMD_PAGE +: 2];
  assign wr0 = reg_wr && page == PAGE0;
  assign wr1 = reg_wr && page == PAGE1;
  assign rd0 = reg_rd && page == PAGE0;

  always_comb begin
    command_next = command_reg;
    interrupt_flags_next = interrupt_flags_reg;
    interrupt_enable_mask_next = interrupt_enable_mask_reg;
    data_config_next = data_config_reg;
    tx_config_next = tx_config_reg;
    rx_config_next = rx_config_reg;
    hash_filter_bits_next = hash_filter_bits_reg;
    if (tx_done) begin
      command_next[CMD_TXGO] = 1'b0;
    end
    if (reg_wr && reg_addr == OFS_CMD) begin
      command_next = reg_wdata;
      // the start command leaves the halted state
      if (reg_wdata[CMD_RUN]) begin
        command_next[CMD_HALT] = 1'b0;
      end
      // transmit-go cannot be withdrawn by a write of zero
      if (command_reg[CMD_TXGO]) begin
        command_next[CMD_TXGO] = 1'b1;
      end
    end
    if (wr0) begin
      unique case (reg_addr)
        OFS_FLAGS: interrupt_flags_next = interrupt_flags_reg & ~reg_wdata;
        OFS_RCFG: rx_config_next = reg_wdata;
        OFS_TCFG: tx_config_next = reg_wdata;
        OFS_DCFG: data_config_next = reg_wdata;
        OFS_MASK: interrupt_enable_mask_next = reg_wdata;
        default: begin
        end
      endcase
    end
    if (wr1 && reg_addr >= OFS_FILTER) begin
      hash_filter_bits_next[{reg_addr[2:0], 3'h0} +: 8] = reg_wdata;
    end
    // hardware set wins over a same-cycle clear
    if (|msb_rise) begin
      interrupt_flags_next[FLAG_TALLY] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      command_reg <= CMD_RESET;
      interrupt_flags_reg <= FLAGS_RESET;
      interrupt_enable_mask_reg <= 8'h00;
      data_config_reg <= DCFG_RESET;
      tx_config_reg <= 8'h00;
      rx_config_reg <= 8'h00;
      hash_filter_bits_reg <= 64'h0;
    end else begin
      command_reg <= command_next;
      interrupt_flags_reg <= interrupt_flags_next;
      interrupt_enable_mask_reg <= interrupt_enable_mask_next;
      data_config_reg <= data_config_next;
      tx_config_reg <= tx_config_next;
      rx_config_reg <= rx_config_next;
      hash_filter_bits_reg <= hash_filter_bits_next;
    end
  end

  // ==================== multicast hash filter
  logic [31:0] crc_reg, crc_next, crc_step;
  logic first_reg, first_next;
  logic group_reg, group_next;
  logic [5:0] hash_reg, hash_next;
  logic mc_valid_next, mc_accept_next;
  logic [63:0] hash_onehot;

  always_comb begin
    crc_step = {crc_reg[30:0], 1'b0} ^ ((crc_reg[31] ^ da_bit) ? CRC_POLY : 32'h0);
    crc_next = crc_reg;
    first_next = first_reg;
    group_next = group_reg;
    hash_next = hash_reg;
    mc_valid_next = 1'b0;
    if (frame_start) begin
      crc_next = CRC_INIT;
      first_next = 1'b1;
    end else if (da_bit_valid) begin
      crc_next = crc_step;
      first_next = 1'b0;
      if (first_reg) begin
        group_next = da_bit;
      end
      if (da_last) begin
        hash_next = crc_step[HASH_LSB +: 6];
        mc_valid_next = group_reg;
      end
    end
    hash_onehot = 64'h1 << hash_reg;
    mc_accept_next = mc_valid_reg ? |(hash_onehot & hash_filter_bits_reg)
      : mc_accept_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_reg <= CRC_INIT;
      first_reg <= 1'b1;
      group_reg <= 1'b0;
      hash_reg <= 6'h0;
      mc_valid_reg <= 1'b0;
      mc_accept_reg <= 1'b0;
    end else begin
      crc_reg <= crc_next;
      first_reg <= first_next;
      group_reg <= group_next;
      hash_reg <= hash_next;
      mc_valid_reg <= mc_valid_next;
      mc_accept_reg <= mc_accept_next;
    end
  end

  // ==================== tally counters
  logic [2:0] tally_inc, tally_rd;
  logic [7:0] alignment_error_tally, crc_error_tally, lost_frame_tally;
  logic accepted;

  always_comb begin
    accepted = pkt_done && addr_match && !halted_reg;
    tally_inc[0] = accepted && align_err;
    tally_inc[1] = accepted && crc_err;
    tally_inc[2] = rx_config_reg[RCFG_MONITOR] ? accepted : no_buffer;
    tally_rd[0] = rd0 && reg_addr == OFS_TALLY_A;
    tally_rd[1] = rd0 && reg_addr == OFS_TALLY_C;
    tally_rd[2] = rd0 && reg_addr == OFS_TALLY_L;
  end

  rfti_tally u_align (.clk(clk), .resetn(resetn), .inc(tally_inc[0]), .rd_clr(tally_rd[0]),
    .count_reg(alignment_error_tally), .msb_rise_reg(msb_rise[0]));
  rfti_tally u_crc (.clk(clk), .resetn(resetn), .inc(tally_inc[1]), .rd_clr(tally_rd[1]),
    .count_reg(crc_error_tally), .msb_rise_reg(msb_rise[1]));
  rfti_tally u_lost (.clk(clk), .resetn(resetn), .inc(tally_inc[2]), .rd_clr(tally_rd[2]),
    .count_reg(lost_frame_tally), .msb_rise_reg(msb_rise[2]));

  // ==================== loopback byte port
  logic [7:0] lb_mem_reg [8];
  logic [7:0] lb_mem_next [8];
  logic [2:0] lb_wp_reg, lb_wp_next, lb_rp_reg, lb_rp_next;
  logic lb_rd;

  always_comb begin
    lb_mem_next = lb_mem_reg;
    lb_wp_next = lb_wp_reg;
    lb_rp_next = lb_rp_reg;
    lb_rd = rd0 && reg_addr == OFS_LBPORT;
    if (lb_byte_valid) begin
      // ring overwrites oldest, so the last eight bytes remain
      lb_mem_next[lb_wp_reg] = lb_byte;
      lb_wp_next = lb_wp_reg + 3'h1;
      lb_rp_next = lb_wp_reg + 3'h1;
    end else if (lb_rd) begin
      lb_rp_next = lb_rp_reg + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lb_mem_reg <= '{default: 8'h00};
      lb_wp_reg <= 3'h0;
      lb_rp_reg <= 3'h0;
    end else begin
      lb_mem_reg <= lb_mem_next;
      lb_wp_reg <= lb_wp_next;
      lb_rp_reg <= lb_rp_next;
    end
  end

  // ==================== collisions and transmit status
  logic [3:0] collision_count_reg, collision_count_next;
  logic [7:0] tx_status_reg, tx_status_next;
  logic txgo_set;

  always_comb begin
    txgo_set = reg_wr && reg_addr == OFS_CMD && reg_wdata[CMD_TXGO];
    collision_count_next = collision_count_reg;
    tx_status_next = tx_status_reg;
    if (txgo_set) begin
      collision_count_next = 4'h0;
      tx_status_next = 8'h00;
    end else if (tx_excess) begin
      tx_status_next[TSR_ABT] = 1'b1;
      collision_count_next = 4'h0;
    end else if (tx_collision) begin
      tx_status_next[TSR_COL] = 1'b1;
      if (collision_count_reg != NCOL_MAX) begin
        collision_count_next = collision_count_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      collision_count_reg <= 4'h0;
      tx_status_reg <= 8'h00;
    end else begin
      collision_count_reg <= collision_count_next;
      tx_status_reg <= tx_status_next;
    end
  end

  // ==================== read mux and status outputs
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd && reg_addr == OFS_CMD) begin
      rdata_next = command_reg;
    end else if (reg_rd && page == PAGE1 && reg_addr >= OFS_FILTER) begin
      rdata_next = hash_filter_bits_reg[{reg_addr[2:0], 3'h0} +: 8];
    end else if (rd0) begin
      unique case (reg_addr)
        OFS_TSR: rdata_next = tx_status_reg;
        OFS_NCOL: rdata_next = {4'h0, collision_count_reg};
        OFS_LBPORT: rdata_next = lb_mem_reg[lb_rp_reg];
        OFS_FLAGS: rdata_next = interrupt_flags_reg;
        OFS_TALLY_A: rdata_next = alignment_error_tally;
        OFS_TALLY_C: rdata_next = crc_error_tally;
        OFS_TALLY_L: rdata_next = lost_frame_tally;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_reg <= 8'h00;
      halted_reg <= 1'b1;
      transmit_go_reg <= 1'b0;
      loop_mode_reg <= RFTI_NORMAL;
    end else begin
      reg_rdata_reg <= rdata_next;
      halted_reg <= command_next[CMD_HALT];
      transmit_go_reg <= command_next[CMD_TXGO] && !command_next[CMD_HALT];
      loop_mode_reg <= rfti_loop_t'({tx_config_next[LOOP_HI], tx_config_next[LOOP_LO]});
    end
  end

  // ==================== checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_lb_read;
    rd0 && reg_addr == OFS_LBPORT && !lb_byte_valid;
  endsequence
  sequence s_start_cmd;
    reg_wr && reg_addr == OFS_CMD && reg_wdata[CMD_RUN];
  endsequence

  a_hash_latch: assert property (
    da_bit_valid && da_last && !frame_start |=> hash_reg == $past(crc_step[31:26]))
    else $error("hash not latched from crc");
  // filter bits may be rewritten in the lookup cycle, so judge against the old ones
  a_filter_pick: assert property (
    mc_valid_reg |=> mc_accept_reg == $past(hash_filter_bits_reg[hash_reg]))
    else $error("accept does not follow filter bit");
  a_lb_advance: assert property (s_lb_read |=> lb_rp_reg == $past(lb_rp_reg) + 3'h1)
    else $error("loopback pointer did not advance");
  // a back-to-back command write may legally halt again
  a_start_run: assert property (
    s_start_cmd |=> !halted_reg ##1 (!halted_reg || $past(reg_wr && reg_addr == OFS_CMD)))
    else $error("start command left device halted");
  a_txgo_clears: assert property (
    txgo_set |=> collision_count_reg == 4'h0 && tx_status_reg == 8'h00)
    else $error("transmit-go did not clear collisions");
  a_excess_abort: assert property (
    tx_excess && !txgo_set |=> tx_status_reg[TSR_ABT] && collision_count_reg == 4'h0)
    else $error("abort not flagged on excess");
  a_col_zero: assert property (!tx_status_reg[TSR_COL] |-> collision_count_reg == 4'h0)
    else $error("collisions counted without flag");
  a_flag_set: assert property (|msb_rise |=> interrupt_flags_reg[FLAG_TALLY])
    else $error("tally flag lost");
  a_loop_code: assert property (
    wr0 && reg_addr == OFS_TCFG |=> loop_mode_reg == rfti_loop_t'($past(reg_wdata[2:1])))
    else $error("loop select mismatch");
endmodule : rfti_top
`default_nettype wire

// ### bench/rfti_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfti_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata_reg,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  import rfti_pkg::*;
  localparam logic [7:0] RING_FIRST = 8'h46;
  localparam logic [7:0] RING_END = 8'h80;
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // ==================== bus cycles
  // strobe drops one cycle before the next can rise
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata_reg;
  endtask : rd
  // ==================== bring-up
  // offsets outside this block are written anyway to keep the order
  task automatic init(input logic [7:0] tcfg_final);
    wr(OFS_CMD, CMD_RESET);
    wr(OFS_DCFG, DCFG_RESET);
    wr(4'ha, 8'h00);
    wr(4'hb, 8'h00);
    wr(OFS_RCFG, 8'h00);
    wr(OFS_TCFG, 8'h02);
    wr(4'h1, RING_FIRST);
    wr(4'h2, RING_END);
    wr(4'h3, RING_FIRST);
    wr(OFS_FLAGS, 8'hff);
    wr(OFS_MASK, 8'h00);
    wr(OFS_CMD, 8'h61);
    for (int i = 1; i < 7; i++) wr(4'(i), 8'h02);
    for (int i = 0; i < 8; i++) wr(OFS_FILTER + 4'(i), 8'hff);
    wr(4'h7, RING_FIRST);
    wr(OFS_CMD, 8'h22);
    wr(OFS_TCFG, tcfg_final);
  endtask : init
endmodule : rfti_host_model
`default_nettype wire

// ### bench/rfti_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
  end \
end
module rfti_top_tb_top;
  import rfti_pkg::*;
  logic clk = 1'b0;
  logic resetn, frame_start, da_bit_valid, da_bit, da_last, pkt_done, addr_match;
  logic align_err, crc_err, no_buffer, lb_byte_valid, tx_collision, tx_excess, tx_done;
  logic [7:0] lb_byte, reg_wdata, reg_rdata_reg;
  logic [3:0] reg_addr;
  logic reg_wr, reg_rd, mc_valid_reg, mc_accept_reg, halted_reg, transmit_go_reg;
  rfti_loop_t loop_mode_reg;
  int n_errors = 0;
  int total_checks = 0;
  always #12.5 clk = ~clk;
  rfti_host_model rfti_host_model_i (.clk(clk), .reg_rdata_reg(reg_rdata_reg),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  rfti_top rfti_top_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg),
    .frame_start(frame_start), .da_bit_valid(da_bit_valid), .da_bit(da_bit),
    .da_last(da_last), .pkt_done(pkt_done), .addr_match(addr_match), .align_err(align_err),
    .crc_err(crc_err), .no_buffer(no_buffer), .lb_byte_valid(lb_byte_valid),
    .lb_byte(lb_byte), .tx_collision(tx_collision), .tx_excess(tx_excess),
    .tx_done(tx_done), .mc_valid_reg(mc_valid_reg), .mc_accept_reg(mc_accept_reg),
    .halted_reg(halted_reg), .transmit_go_reg(transmit_go_reg),
    .loop_mode_reg(loop_mode_reg));
  // ==================== helpers
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rfti_host_model_i.rd(a, d);
    `CHK(d, e)
  endtask : rchk
  task automatic pkt(input logic m, input logic a, input logic c);
    @(negedge clk);
    {pkt_done, addr_match, align_err, crc_err} = {1'b1, m, a, c};
    @(negedge clk);
    {pkt_done, addr_match, align_err, crc_err} = 4'h0;
  endtask : pkt
  task automatic ev(input int w);
    @(negedge clk);
    {no_buffer, tx_done, tx_excess, tx_collision} = 4'(1 << w);
    @(negedge clk);
    {no_buffer, tx_done, tx_excess, tx_collision} = 4'h0;
  endtask : ev
  // independent crc model, first address bit shifted first
  function automatic logic [5:0] hash_of(input logic [47:0] da);
    logic [31:0] c;
    c = CRC_INIT;
    for (int k = 0; k < 48; k++) c = {c[30:0], 1'b0} ^ ((c[31] ^ da[k]) ? CRC_POLY : 32'h0);
    return c[31:26];
  endfunction : hash_of
  task automatic send_da(input logic [47:0] da, input logic exp);
    int k;
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    for (k = 0; k < 48; k++) begin
      {da_bit_valid, da_bit, da_last} = {1'b1, da[k], k == 47};
      @(negedge clk);
    end
    {da_bit_valid, da_last} = 2'b00;
    k = 0;
    while (mc_valid_reg !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    if (k == 4) begin
      n_errors++;
      end_sim();
    end
    @(negedge clk);
    `CHK(mc_accept_reg, exp)
  endtask : send_da
  // ==================== scenarios
  task automatic t_reset();
    `CHK(transmit_go_reg, 1'b0)
    `CHK(loop_mode_reg, RFTI_NORMAL)
    rchk(OFS_CMD, CMD_RESET);
    rchk(OFS_FLAGS, FLAGS_RESET);
    pkt(1'b1, 1'b1, 1'b0);
    rchk(OFS_TALLY_A, 8'h00);
    `CHK(halted_reg, 1'b1)
  endtask : t_reset
  task automatic t_init();
    rfti_host_model_i.init(8'h00);
    `CHK(halted_reg, 1'b0)
    rchk(OFS_FLAGS, 8'h00);
    for (int i = 1; i < 4; i++) begin
      rfti_host_model_i.wr(OFS_TCFG, 8'(i << 1));
      @(negedge clk);
      `CHK(loop_mode_reg, rfti_loop_t'(i))
      rfti_host_model_i.wr(OFS_TCFG, 8'h00);
      @(negedge clk);
      `CHK(loop_mode_reg, RFTI_NORMAL)
    end
  endtask : t_init
  task automatic t_hash();
    logic [47:0] da;
    logic [5:0] h;
    da = 48'h5a3c_1e0f_9b01;
    h = hash_of(da);
    send_da(da, 1'b1);
    for (int s = 0; s < 2; s++) begin
      rfti_host_model_i.wr(OFS_CMD, 8'h62);
      for (int r = 0; r < 8; r++) begin
        rfti_host_model_i.wr(OFS_FILTER + 4'(r),
          (r == int'(h[5:3])) ? (8'h01 << (h[2:0] ^ 3'(s))) : 8'h00);
      end
      rchk(OFS_FILTER + 4'(h[5:3]), 8'h01 << (h[2:0] ^ 3'(s)));
      rfti_host_model_i.wr(OFS_CMD, 8'h22);
      send_da(da, s == 0);
    end
  endtask : t_hash
  task automatic t_tally();
    logic [7:0] d;
    pkt(1'b1, 1'b1, 1'b0);
    pkt(1'b0, 1'b1, 1'b1);
    pkt(1'b1, 1'b0, 1'b1);
    pkt(1'b1, 1'b1, 1'b1);
    ev(3);
    ev(3);
    rchk(OFS_TALLY_A, 8'h02);
    rchk(OFS_TALLY_C, 8'h02);
    rchk(OFS_TALLY_L, 8'h02);
    rchk(OFS_TALLY_A, 8'h00);
    rfti_host_model_i.wr(OFS_RCFG, 8'h20);
    repeat (3) pkt(1'b1, 1'b0, 1'b0);
    pkt(1'b0, 1'b0, 1'b0);
    rchk(OFS_TALLY_L, 8'h03);
    rfti_host_model_i.wr(OFS_RCFG, 8'h00);
    rfti_host_model_i.wr(OFS_FLAGS, 8'hff);
    repeat (200) pkt(1'b1, 1'b0, 1'b1);
    rchk(OFS_FLAGS, 8'h20);
    rchk(OFS_TALLY_C, TALLY_MAX);
    pkt(1'b1, 1'b1, 1'b0);
    fork
      rfti_host_model_i.rd(OFS_TALLY_A, d);
      pkt(1'b1, 1'b1, 1'b0);
    join
    `CHK(d, 8'h01)
    rchk(OFS_TALLY_A, 8'h01);
  endtask : t_tally
  task automatic t_lb();
    rfti_host_model_i.wr(OFS_TCFG, 8'h02);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      {lb_byte_valid, lb_byte} = {1'b1, 8'(8'h30 + k)};
    end
    @(negedge clk);
    lb_byte_valid = 1'b0;
    for (int k = 2; k < 10; k++) rchk(OFS_LBPORT, 8'(8'h30 + k));
    rfti_host_model_i.wr(OFS_TCFG, 8'h00);
  endtask : t_lb
  task automatic t_col();
    rfti_host_model_i.wr(OFS_CMD, 8'h26);
    `CHK(transmit_go_reg, 1'b1)
    rchk(OFS_NCOL, 8'h00);
    rchk(OFS_TSR, 8'h00);
    repeat (3) ev(0);
    rchk(OFS_NCOL, 8'h03);
    ev(2);
    `CHK(transmit_go_reg, 1'b0)
    rfti_host_model_i.wr(OFS_CMD, 8'h26);
    rchk(OFS_NCOL, 8'h00);
    repeat (2) ev(0);
    ev(1);
    rchk(OFS_NCOL, 8'h00);
    rchk(OFS_TSR, 8'h0c);
  endtask : t_col
  // reset in mid-run, with transmit-go, a loop mode and the tally flag all set
  task automatic t_reset2();
    rfti_host_model_i.wr(OFS_TCFG, 8'h04);
    `CHK(loop_mode_reg, RFTI_LOOP_CODEC)
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    `CHK(halted_reg, 1'b1)
    `CHK(transmit_go_reg, 1'b0)
    `CHK(loop_mode_reg, RFTI_NORMAL)
    rchk(OFS_CMD, CMD_RESET);
    rchk(OFS_FLAGS, FLAGS_RESET);
  endtask : t_reset2
  // ==================== main sequence
  initial begin
    {frame_start, da_bit_valid, da_bit, da_last, pkt_done, addr_match} = 6'h0;
    {align_err, crc_err, no_buffer, lb_byte_valid, tx_collision, tx_excess} = 6'h0;
    tx_done = 1'b0;
    lb_byte = 8'h00;
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_init();
    t_hash();
    t_tally();
    t_lb();
    t_col();
    t_reset2();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule : rfti_top_tb_top
`undef CHK
`default_nettype wire
